// ==== rial_front.sv ====
/*
 * Host visible front end of the real-time-clock indirect access path:
 * lock and key register, address and control register, data register.
 * Assumes the register port and the timekeeping core both run on core_clk,
 * and that the core answers each request with a one-cycle ack.
 */
`timescale 1ns/1ps

// How it works
// - Key register reads state code; reset locks.
// - Locked plus first key awaits second.
// - First then second key unlocks interface.
// - Wrong second key disables until reset.
// - Any key write while unlocked relocks.
// - Disabled state ignores key writes.
// - Bit 7 busy; writing one starts read.
// - Bit 6 is read/write autoread enable.
// - Bit 5 reads zero, writes ignored.
// - Bit 4 enables short strobe; set it.
// - Bits 3:0 select internal target register.
// - Address steps after capture/alarm transfers.
// - Data register holds last transferred byte.
// - Data register write starts indirect write.
// - Autoread: data read starts next read.
// - Data access or busy-bit write while locked disables the interface.
// - Capture 0x00-0x03, alarm 0x08-0x0B step address.
module rial_front (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Device register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Timekeeping core indirect port
    output logic rtc_req,
    output logic rtc_we,
    output logic [3:0] rtc_addr,
    output logic [7:0] rtc_wdata,
    output logic rtc_short,
    input wire logic [7:0] rtc_rdata,
    input wire logic rtc_ack
);
    rial_pkg::rial_lock_type lock_state, next_lock_state;
    rial_pkg::rial_xfer_type xfer_state, next_xfer_state;
    logic auto_read_enable, next_auto_read_enable;
    logic short_strobe, next_short_strobe;
    logic [3:0] target_addr, next_target_addr;
    logic [7:0] data_byte, next_data_byte;
    logic [7:0] next_reg_rdata;
    logic next_rtc_req, next_rtc_we;

    logic key_wr, adr_wr, dat_wr, dat_rd;
    logic is_open, busy, grouped;
    logic [7:0] lock_code, adr_view;

    assign key_wr = reg_wr && reg_addr == rial_pkg::KEY_OFFSET;
    assign adr_wr = reg_wr && reg_addr == rial_pkg::ADR_OFFSET;
    assign dat_wr = reg_wr && reg_addr == rial_pkg::DAT_OFFSET;
    assign dat_rd = reg_rd && reg_addr == rial_pkg::DAT_OFFSET;
    assign is_open = lock_state == rial_pkg::LOCK_OPEN;
    assign busy = xfer_state != rial_pkg::XFER_IDLE;
    assign grouped = target_addr[3:2] == rial_pkg::CAPTURE_GROUP ||
                     target_addr[3:2] == rial_pkg::ALARM_GROUP;

    always_comb begin
        unique case (lock_state)
            rial_pkg::LOCK_CLOSED: lock_code = rial_pkg::CODE_LOCKED;
            rial_pkg::LOCK_WAIT_SECOND:
                lock_code = rial_pkg::CODE_WAIT_SECOND;
            rial_pkg::LOCK_OPEN: lock_code = rial_pkg::CODE_UNLOCKED;
            rial_pkg::LOCK_DISABLED: lock_code = rial_pkg::CODE_DISABLED;
        endcase
    end

    always_comb begin
        adr_view = 8'h00;
        adr_view[rial_pkg::BUSY_BIT] = busy;
        adr_view[rial_pkg::AUTO_BIT] = auto_read_enable;
        adr_view[rial_pkg::SHORT_BIT] = short_strobe;
        adr_view[rial_pkg::ADDR_MSB:rial_pkg::ADDR_LSB] = target_addr;
    end

    // Lock and key state. A data access or a busy-bit address write that is not allowed
    // counts as an attempt on a locked interface and trips the lockout.
    always_comb begin
        next_lock_state = lock_state;
        if (key_wr) begin
            unique case (lock_state)
                rial_pkg::LOCK_CLOSED: begin
                    if (reg_wdata == rial_pkg::KEY_FIRST)
                        next_lock_state = rial_pkg::LOCK_WAIT_SECOND;
                    else
                        next_lock_state = rial_pkg::LOCK_DISABLED;
                end
                rial_pkg::LOCK_WAIT_SECOND: begin
                    if (reg_wdata == rial_pkg::KEY_SECOND)
                        next_lock_state = rial_pkg::LOCK_OPEN;
                    else
                        next_lock_state = rial_pkg::LOCK_DISABLED;
                end
                rial_pkg::LOCK_OPEN:
                    next_lock_state = rial_pkg::LOCK_CLOSED;
                rial_pkg::LOCK_DISABLED:
                    next_lock_state = rial_pkg::LOCK_DISABLED;
            endcase
        end else if (!is_open && lock_state != rial_pkg::LOCK_DISABLED &&
                     ((adr_wr && reg_wdata[rial_pkg::BUSY_BIT]) || dat_wr ||
                      dat_rd)) begin
            next_lock_state = rial_pkg::LOCK_DISABLED;
        end
    end

    // Address, control and data registers and the indirect transfer.
    // Requests made while busy are dropped; software polls busy first.
    always_comb begin
        next_xfer_state = xfer_state;
        next_auto_read_enable = auto_read_enable;
        next_short_strobe = short_strobe;
        next_target_addr = target_addr;
        next_data_byte = data_byte;
        next_rtc_req = 1'b0;
        next_rtc_we = rtc_we;
        next_reg_rdata = 8'h00;
        if (reg_rd) begin
            if (reg_addr == rial_pkg::KEY_OFFSET)
                next_reg_rdata = lock_code;
            else if (reg_addr == rial_pkg::ADR_OFFSET && is_open)
                next_reg_rdata = adr_view;
            else if (reg_addr == rial_pkg::DAT_OFFSET && is_open)
                next_reg_rdata = data_byte;
        end
        unique case (xfer_state)
            rial_pkg::XFER_IDLE: begin
                if (is_open && adr_wr) begin
                    next_auto_read_enable =
                        reg_wdata[rial_pkg::AUTO_BIT];
                    next_short_strobe = reg_wdata[rial_pkg::SHORT_BIT];
                    next_target_addr =
                        reg_wdata[rial_pkg::ADDR_MSB:rial_pkg::ADDR_LSB];
                    if (reg_wdata[rial_pkg::BUSY_BIT]) begin
                        next_xfer_state = rial_pkg::XFER_READ;
                        next_rtc_req = 1'b1;
                        next_rtc_we = 1'b0;
                    end
                end else if (is_open && dat_wr) begin
                    next_data_byte = reg_wdata;
                    next_xfer_state = rial_pkg::XFER_WRITE;
                    next_rtc_req = 1'b1;
                    next_rtc_we = 1'b1;
                end else if (is_open && dat_rd && auto_read_enable) begin
                    next_xfer_state = rial_pkg::XFER_READ;
                    next_rtc_req = 1'b1;
                    next_rtc_we = 1'b0;
                end
            end
            rial_pkg::XFER_READ, rial_pkg::XFER_WRITE: begin
                if (rtc_ack) begin
                    if (xfer_state == rial_pkg::XFER_READ)
                        next_data_byte = rtc_rdata;
                    next_xfer_state = rial_pkg::XFER_IDLE;
                    if (grouped)
                        next_target_addr = target_addr +
                            rial_pkg::ADDR_STEP;
                end
            end
            default: next_xfer_state = rial_pkg::XFER_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            lock_state <= rial_pkg::LOCK_CLOSED;
            xfer_state <= rial_pkg::XFER_IDLE;
            auto_read_enable <= 1'b0;
            short_strobe <= 1'b0;
            target_addr <= rial_pkg::ADDR_RESET;
            data_byte <= rial_pkg::DATA_RESET;
            reg_rdata <= 8'h00;
            rtc_req <= 1'b0;
            rtc_we <= 1'b0;
        end else begin
            lock_state <= next_lock_state;
            xfer_state <= next_xfer_state;
            auto_read_enable <= next_auto_read_enable;
            short_strobe <= next_short_strobe;
            target_addr <= next_target_addr;
            data_byte <= next_data_byte;
            reg_rdata <= next_reg_rdata;
            rtc_req <= next_rtc_req;
            rtc_we <= next_rtc_we;
        end
    end

    assign rtc_addr = target_addr;
    assign rtc_wdata = data_byte;
    assign rtc_short = short_strobe;

    sequence s_key(logic [7:0] code, logic [7:0] value);
        lock_code == code && key_wr && reg_wdata == value;
    endsequence

    // The waiting code already records the first key, so the second key
    // alone completes the pair however long the gap between them was.
    sequence s_key_pair;
        s_key(rial_pkg::CODE_WAIT_SECOND, rial_pkg::KEY_SECOND);
    endsequence

    a_reset_locked: assert property (@(posedge core_clk)
        rst |=> lock_code == rial_pkg::CODE_LOCKED)
        else $error("lock state not cleared by reset");
    a_first_key: assert property (@(posedge core_clk) disable iff (rst)
        s_key(rial_pkg::CODE_LOCKED, rial_pkg::KEY_FIRST)
        |=> lock_code == rial_pkg::CODE_WAIT_SECOND)
        else $error("first key did not advance the lock");
    a_key_unlock: assert property (@(posedge core_clk) disable iff (rst)
        s_key_pair |=> lock_code == rial_pkg::CODE_UNLOCKED && is_open)
        else $error("key pair did not unlock");
    a_wrong_key: assert property (@(posedge core_clk) disable iff (rst)
        lock_code == rial_pkg::CODE_WAIT_SECOND && key_wr &&
        reg_wdata != rial_pkg::KEY_SECOND
        |=> lock_code == rial_pkg::CODE_DISABLED)
        else $error("wrong second key did not disable");
    a_key_relock: assert property (@(posedge core_clk) disable iff (rst)
        is_open && key_wr |=> lock_code == rial_pkg::CODE_LOCKED)
        else $error("key write while open did not relock");
    a_lockout_held: assert property (@(posedge core_clk)
        disable iff (rst)
        lock_code == rial_pkg::CODE_DISABLED
        |=> lock_code == rial_pkg::CODE_DISABLED [*3])
        else $error("lockout left without reset");
    a_busy_start: assert property (@(posedge core_clk) disable iff (rst)
        is_open && !busy && adr_wr && reg_wdata[rial_pkg::BUSY_BIT]
        |=> busy && rtc_req && !rtc_we)
        else $error("busy write did not start a read");
    a_bit5_zero: assert property (@(posedge core_clk) disable iff (rst)
        reg_rd && reg_addr == rial_pkg::ADR_OFFSET |=> !reg_rdata[5])
        else $error("unused address bit read as one");
    a_write_start: assert property (@(posedge core_clk)
        disable iff (rst)
        is_open && !busy && dat_wr
        |=> rtc_req && rtc_we && rtc_wdata == $past(reg_wdata))
        else $error("data write did not start an indirect write");
    a_locked_access: assert property (@(posedge core_clk)
        disable iff (rst)
        lock_code == rial_pkg::CODE_LOCKED && !key_wr && dat_wr
        |=> lock_code == rial_pkg::CODE_DISABLED ##1 !busy)
        else $error("access while locked did not disable");
    a_addr_step: assert property (@(posedge core_clk) disable iff (rst)
        busy && rtc_ack && grouped
        |=> target_addr == $past(target_addr) + rial_pkg::ADDR_STEP)
        else $error("grouped address did not step");
    a_busy_clear: assert property (@(posedge core_clk) disable iff (rst)
        busy && rtc_ack |=> !busy)
        else $error("busy stayed set after completion");
endmodule : rial_front

// ==== rial_pkg.sv ====
/*
 * Constants for the clock indirect access front end: register offsets,
 * key codes, lock status codes, address register field positions and the
 * internal address ranges that step the address after each transfer.
 * Assumes nothing of its surroundings; both the module and the bench files read it.
 */
package rial_pkg;
    // Register offsets on the device register map.
    localparam logic [7:0] KEY_OFFSET = 8'h0A;
    localparam logic [7:0] ADR_OFFSET = 8'h0B;
    localparam logic [7:0] DAT_OFFSET = 8'h0C;

    // Key codes written in order to open the interface.
    localparam logic [7:0] KEY_FIRST = 8'hA5;
    localparam logic [7:0] KEY_SECOND = 8'hF1;

    // Status codes read back from the lock and key register.
    localparam logic [7:0] CODE_LOCKED = 8'h00;
    localparam logic [7:0] CODE_WAIT_SECOND = 8'h01;
    localparam logic [7:0] CODE_UNLOCKED = 8'h02;
    localparam logic [7:0] CODE_DISABLED = 8'h03;

    // Address register fields.
    localparam int BUSY_BIT = 7;
    localparam int AUTO_BIT = 6;
    localparam int SHORT_BIT = 4;
    localparam int ADDR_MSB = 3;
    localparam int ADDR_LSB = 0;

    // Reset values.
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [3:0] ADDR_RESET = 4'h0;

    // Upper two bits of the internal address that mark the capture group
    // (0x00 to 0x03) and the alarm group (0x08 to 0x0B).
    localparam logic [1:0] CAPTURE_GROUP = 2'h0;
    localparam logic [1:0] ALARM_GROUP = 2'h2;
    localparam logic [3:0] ADDR_STEP = 4'h1;

    typedef enum logic [1:0] {
        LOCK_CLOSED,
        LOCK_WAIT_SECOND,
        LOCK_OPEN,
        LOCK_DISABLED
    } rial_lock_type;

    typedef enum logic [1:0] {
        XFER_IDLE,
        XFER_READ,
        XFER_WRITE
    } rial_xfer_type;
endpackage : rial_pkg

// ==== rial_front_tb.sv ====
/*
 * Self-checking bench for the clock indirect access front end: the lock
 * and key sequence, indirect reads and writes, autoread and address steps.
 * Assumes rial_pkg and rial_front are compiled first; the bench itself
 * plays both the host and the timekeeping core.
 */
`timescale 1ns/1ps

module rial_front_tb;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic rtc_req;
    logic rtc_we;
    logic [3:0] rtc_addr;
    logic [7:0] rtc_wdata;
    logic rtc_short;
    logic [7:0] rtc_rdata = 8'h00;
    logic rtc_ack = 1'b0;
    int fail_count = 0;
    int checks_done = 0;
    logic [7:0] d;

    localparam logic [7:0] KEY = rial_pkg::KEY_OFFSET;
    localparam logic [7:0] ADR = rial_pkg::ADR_OFFSET;
    localparam logic [7:0] DAT = rial_pkg::DAT_OFFSET;

    always #25 core_clk = ~core_clk;

    rial_front DUT (
        .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .rtc_req(rtc_req), .rtc_we(rtc_we),
        .rtc_addr(rtc_addr), .rtc_wdata(rtc_wdata), .rtc_short(rtc_short),
        .rtc_rdata(rtc_rdata), .rtc_ack(rtc_ack)
    );

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic do_reset;
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        #1;
    endtask : do_reset

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr

    // Read data is registered, so it is sampled just after the taking edge.
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask : rd

    // The core's data lines carry junk outside the ack so stale values show.
    task automatic ack(input logic [7:0] v);
        @(posedge core_clk);
        rtc_ack <= 1'b1;
        rtc_rdata <= v;
        @(posedge core_clk);
        rtc_ack <= 1'b0;
        rtc_rdata <= ~v;
        #1;
    endtask : ack

    task automatic t_reset_state;
        do_reset();
        chk({rtc_req, rtc_we, rtc_short, 1'b0, rtc_addr}, 8'h00);
        chk(rtc_wdata, rial_pkg::DATA_RESET);
        rd(KEY, d); chk(d, rial_pkg::CODE_LOCKED);
        $display("reset state test done");
    endtask : t_reset_state

    task automatic t_unlock;
        wr(KEY, rial_pkg::KEY_FIRST);
        rd(KEY, d); chk(d, rial_pkg::CODE_WAIT_SECOND);
        wr(KEY, rial_pkg::KEY_SECOND);
        rd(KEY, d); chk(d, rial_pkg::CODE_UNLOCKED);
        $display("unlock test done");
    endtask : t_unlock

    task automatic t_read;
        wr(ADR, 8'hB0);
        chk({rtc_req, rtc_we, rtc_short, 1'b0, rtc_addr}, 8'hA0);
        rd(ADR, d); chk(d, 8'h90);
        ack(8'h3C);
        rd(DAT, d); chk(d, 8'h3C);
        chk({7'h00, rtc_req}, 8'h00);
        rd(ADR, d); chk(d, 8'h11);
        rd(8'h0D, d); chk(d, 8'h00);
        $display("indirect read test done");
    endtask : t_read

    task automatic t_write;
        wr(ADR, 8'h1B);
        wr(DAT, 8'h55);
        chk({rtc_req, rtc_we, 2'h0, rtc_addr}, 8'hCB);
        chk(rtc_wdata, 8'h55);
        ack(8'h00);
        rd(ADR, d); chk(d, 8'h1C);
        rd(DAT, d); chk(d, 8'h55);
        wr(ADR, 8'h15);
        wr(DAT, 8'h66);
        ack(8'h00);
        rd(ADR, d); chk(d, 8'h15);
        $display("indirect write test done");
    endtask : t_write

    task automatic t_autoread;
        wr(ADR, 8'hD3);
        ack(8'h11);
        rd(DAT, d); chk(d, 8'h11);
        chk({rtc_req, 3'h0, rtc_addr}, 8'h84);
        ack(8'h22);
        rd(DAT, d); chk(d, 8'h22);
        ack(8'h33);
        rd(ADR, d); chk(d, 8'h54);
        $display("autoread test done");
    endtask : t_autoread

    task automatic t_relock;
        wr(KEY, 8'h00);
        rd(KEY, d); chk(d, rial_pkg::CODE_LOCKED);
        wr(DAT, 8'h77);
        rd(KEY, d); chk(d, rial_pkg::CODE_DISABLED);
        chk({7'h00, rtc_req}, 8'h00);
        wr(KEY, rial_pkg::KEY_FIRST);
        rd(KEY, d); chk(d, rial_pkg::CODE_DISABLED);
        $display("relock and disable test done");
    endtask : t_relock

    task automatic t_wrong_key;
        t_reset_state();
        wr(KEY, rial_pkg::KEY_FIRST);
        wr(KEY, 8'h12);
        rd(KEY, d); chk(d, rial_pkg::CODE_DISABLED);
        $display("wrong key test done");
    endtask : t_wrong_key

    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run

    initial begin
        t_reset_state();
        t_unlock();
        t_read();
        t_write();
        t_autoread();
        t_relock();
        t_wrong_key();
        complete_run();
    end

    // The tests need well under 400 cycles; allow many times that.
    initial begin
        #100000;
        fail_count++;
        complete_run();
    end
endmodule : rial_front_tb
